// file: hdl/tmsq_pkg.sv
// Package: constants, modes and timing for the mode sequencer and its host
//
// What this block does
// - Host waits 10 ms after power-on.
// - Host pulses reset low, waits 5 ms.
// - Reference clock activity signals device ready.
// - Preamble listen: wake every T1+T2, receive T2.
// - Preamble found: sequencer off, stay receiving.
// - Idle sleep; start goes low-power, then idle.
// - Receive setting 101 stops on sync.
// - Sync listen: receive only for timeout window.
// - Preamble before timeout: wait sync until T2.
// - Sync found: event, sequencer off, keep receiving.
// - Packet received raises host interrupt request.
// - Beacon: transmit each T1+T2, then idle.
// - Beacon loops until halt bit set.
// - Preamble on line 4 code 11 needs route bit.
// - Host sets first timer to 64 us.
// - Far transmitter preamble at least T1+2*T2.
package tmsq_pkg;
    localparam int CLK_MHZ = 25;
    localparam int POR_WAIT_MS = 10;
    localparam int MAN_WAIT_MS = 5;
    localparam int RESET_PULSE_US = 100;
    localparam int T1_MIN_US = 64;
    localparam int POR_WAIT_CYC = POR_WAIT_MS * 1000 * CLK_MHZ;
    localparam int MAN_WAIT_CYC = MAN_WAIT_MS * 1000 * CLK_MHZ;
    localparam int RESET_PULSE_CYC = RESET_PULSE_US * CLK_MHZ;
    localparam int T1_MIN_CYC = T1_MIN_US * CLK_MHZ;
    localparam int TW = 24;
    localparam logic [TW-1:0] T1_DEF = 24'h000640;
    localparam logic [TW-1:0] T2_DEF = 24'h000640;
    localparam logic [TW-1:0] RXTO_DEF = 24'h000100;
    // Chip modes
    localparam logic [2:0] MODE_SLEEP = 3'h0;
    localparam logic [2:0] MODE_STDBY = 3'h1;
    localparam logic [2:0] MODE_TX = 3'h3;
    localparam logic [2:0] MODE_RX = 3'h5;
    localparam logic [1:0] START_TO_LPS = 2'h0;
    localparam logic [2:0] RXT_OFF_PRE = 3'h6;
    localparam logic [2:0] RXT_OFF_SYNC = 3'h5;
    localparam logic [1:0] RXTO_TO_LPS = 2'h2;
    localparam logic [1:0] MAP_PREAMBLE = 2'h3;
    localparam logic [1:0] MAP_SYNC = 2'h3;
    localparam logic [1:0] MAP_CHECK = 2'h1;
    // Host register map (AXI4-Lite byte offsets)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CFG = 8'h04;
    localparam logic [7:0] REG_T1 = 8'h08;
    localparam logic [7:0] REG_T2 = 8'h0C;
    localparam logic [7:0] REG_RXTO = 8'h10;
    localparam logic [7:0] REG_STAT = 8'h14;
    localparam logic [7:0] REG_MODE = 8'h18;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    // CTRL bits
    localparam int CTRL_START = 0;
    localparam int CTRL_HALT = 1;
    localparam int CTRL_RESET = 2;
    localparam int CTRL_WMODE = 3;
    typedef struct packed {
        logic idle_power_select;
        logic [1:0] start_transition;
        logic low_power_choice;
        logic idle_transition;
        logic [2:0] rx_transition;
        logic [1:0] rx_timeout_transition;
        logic tx_transition;
        logic beacon_repeat_enable;
        logic preamble_event_route_bit;
        logic [1:0] map_line4;
        logic [1:0] map_line2;
        logic [1:0] map_line0;
    } tmsq_cfg_t;
    localparam int CFG_W = 19;
endpackage

// file: hdl/tmsq_link_if.sv
// Interface: config, mode and event wires between host and device
`timescale 1ns/1ns
interface tmsq_link_if;
    import tmsq_pkg::*;
    logic ext_reset_n;
    logic ref_clock_out;
    logic cfg_we;
    tmsq_cfg_t cfg;
    logic [TW-1:0] t1_len;
    logic [TW-1:0] t2_len;
    logic [TW-1:0] rxto_len;
    logic start_pulse;
    logic seq_halt_bit;
    logic mode_we;
    logic [2:0] mode_wdata;
    logic [2:0] chip_mode;
    logic seq_on;
    logic event_line_4;
    logic event_line_2;
    logic event_line_0;
    logic irq;
    modport device (
        input ext_reset_n, cfg_we, cfg, t1_len, t2_len, rxto_len, start_pulse,
        input seq_halt_bit, mode_we, mode_wdata,
        output ref_clock_out, chip_mode, seq_on, event_line_4, event_line_2,
        output event_line_0, irq
    );
    modport host (
        output ext_reset_n, cfg_we, cfg, t1_len, t2_len, rxto_len, start_pulse,
        output seq_halt_bit, mode_we, mode_wdata,
        input ref_clock_out, chip_mode, seq_on, event_line_4, event_line_2,
        input event_line_0, irq
    );
endinterface

// file: hdl/tmsq_device.sv
// Device end: top mode sequencer with listen and beacon behaviour
`timescale 1ns/1ns
module tmsq_device
    import tmsq_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Link
    tmsq_link_if.device lnk,
    // Radio event inputs
    input wire logic preamble_found_event,
    input wire logic sync_match_event,
    input wire logic tx_done_event,
    input wire logic rx_payload_event,
    input wire logic check_pass_event
);
    typedef enum logic [5:0] {
        S_OFF = 6'h01,
        S_LPS = 6'h02,
        S_IDLE = 6'h04,
        S_RX = 6'h08,
        S_TX = 6'h10,
        S_BOOT = 6'h20
    } tmsq_st_t;
    typedef struct packed {
        tmsq_st_t st;
        tmsq_cfg_t cfg;
        logic [TW-1:0] t1;
        logic [TW-1:0] t2;
        logic [TW-1:0] rxto;
        logic [TW-1:0] cnt;
        logic [TW-1:0] wcnt;
        logic t2_run;
        logic [2:0] mode;
        logic [2:0] ev_s1;
        logic [2:0] ev_s2;
        logic [1:0] rst_s;
        logic [1:0] ctl_s1;
        logic [1:0] ctl_s2;
        logic [1:0] pr_s1;
        logic [1:0] pr_s2;
        logic [1:0] ex_s1;
        logic [1:0] ex_s2;
        logic [2:0] lines;
        logic irq;
        logic ckdiv;
        logic ready;
        logic [15:0] boot;
        logic pre_seen;
    } tmsq_dev_t;
    tmsq_dev_t r;
    tmsq_dev_t next_r;
    logic pre_ev;
    logic sync_ev;
    logic sent_ev;
    always_comb begin
        next_r = r;
        // Pin inputs and host strobes through two flops; config, lengths and mode data are taken directly
        next_r.ev_s1 = {preamble_found_event, sync_match_event, tx_done_event};
        next_r.ev_s2 = r.ev_s1;
        next_r.rst_s = {r.rst_s[0], lnk.ext_reset_n};
        next_r.ctl_s1 = {lnk.start_pulse, lnk.seq_halt_bit};
        next_r.ctl_s2 = r.ctl_s1;
        next_r.pr_s1 = {rx_payload_event, check_pass_event};
        next_r.pr_s2 = r.pr_s1;
        next_r.ex_s1 = {lnk.mode_we, lnk.cfg_we};
        next_r.ex_s2 = r.ex_s1;
        pre_ev = r.ev_s2[2];
        sync_ev = r.ev_s2[1];
        sent_ev = r.ev_s2[0];
        if (r.ex_s2[0]) begin
            next_r.cfg = lnk.cfg;
            next_r.t1 = lnk.t1_len;
            next_r.t2 = lnk.t2_len;
            next_r.rxto = lnk.rxto_len;
        end
        next_r.cnt = r.cnt + 24'h000001;
        next_r.wcnt = r.wcnt + 24'h000001;
        unique case (r.st)
            S_BOOT: begin
                next_r.boot = r.boot + 16'h0001;
                if (&r.boot) begin
                    next_r.ready = 1'b1;
                    next_r.st = S_OFF;
                end
            end
            S_OFF: begin
                if (r.ex_s2[1]) begin
                    next_r.mode = lnk.mode_wdata;
                end
                if (r.ctl_s2[1] && !r.ctl_s2[0]) begin
                    next_r.st = S_LPS;
                end
            end
            S_LPS: begin
                if (r.cfg.start_transition == START_TO_LPS && r.cfg.low_power_choice) begin
                    next_r.st = S_IDLE;
                    next_r.cnt = '0;
                    next_r.mode = r.cfg.idle_power_select ? MODE_SLEEP : MODE_STDBY;
                end else begin
                    next_r.st = S_OFF;
                end
            end
            S_IDLE: begin
                if (r.cnt >= r.t1) begin
                    next_r.cnt = '0;
                    next_r.wcnt = '0;
                    next_r.t2_run = 1'b1;
                    next_r.pre_seen = 1'b0;
                    if (r.cfg.idle_transition) begin
                        next_r.st = S_RX;
                        next_r.mode = MODE_RX;
                    end else begin
                        next_r.st = S_TX;
                        next_r.mode = MODE_TX;
                    end
                end
            end
            S_RX: begin
                if (pre_ev) begin
                    next_r.pre_seen = 1'b1;
                end
                if (r.cfg.rx_transition == RXT_OFF_PRE && pre_ev) begin
                    next_r.st = S_OFF;
                end else if (r.cfg.rx_transition == RXT_OFF_SYNC && sync_ev) begin
                    next_r.st = S_OFF;
                end else if (r.cfg.rx_transition == RXT_OFF_SYNC && !r.t2_run) begin
                    next_r.st = S_LPS;
                end else if (r.cfg.rx_transition == RXT_OFF_SYNC
                             && r.cfg.rx_timeout_transition == RXTO_TO_LPS
                             && r.wcnt >= r.rxto && !pre_ev && !r.pre_seen && r.t2_run
                             && r.cnt < r.rxto + 24'h000001) begin
                    next_r.st = S_LPS;
                end else if (r.cfg.rx_transition == RXT_OFF_PRE && r.cnt >= r.t2) begin
                    next_r.st = S_LPS;
                end
                if (r.cnt >= r.t2) begin
                    next_r.t2_run = 1'b0;
                end
            end
            S_TX: begin
                if (sent_ev && !r.cfg.tx_transition) begin
                    next_r.st = S_LPS;
                end
            end
            default: next_r.st = S_OFF;
        endcase
        // low power fills the rest of T2 after early exit
        if (r.st == S_LPS && r.t2_run) begin
            next_r.st = S_LPS;
            next_r.cnt = r.cnt + 24'h000001;
            next_r.mode = r.cfg.idle_power_select ? MODE_SLEEP : MODE_STDBY;
            if (r.cnt >= r.t2) begin
                next_r.t2_run = 1'b0;
            end
        end
        if (r.ctl_s2[0] && r.st != S_BOOT) begin
            next_r.st = S_OFF;
            next_r.t2_run = 1'b0;
        end
        // Event routing
        next_r.lines[2] = (r.cfg.map_line4 == MAP_PREAMBLE) && r.cfg.preamble_event_route_bit
            && pre_ev;
        next_r.lines[1] = (r.cfg.map_line2 == MAP_SYNC) && sync_ev;
        next_r.lines[0] = (r.cfg.map_line0 == MAP_CHECK) && r.pr_s2[0];
        next_r.irq = r.pr_s2[1];
        next_r.ckdiv = r.ready ? ~r.ckdiv : 1'b0;
        if (!r.rst_s[1]) begin
            next_r.st = S_BOOT;
            next_r.boot = '0;
            next_r.ready = 1'b0;
            next_r.mode = MODE_STDBY;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.st <= S_BOOT;
            r.mode <= MODE_STDBY;
            r.t1 <= T1_DEF;
            r.t2 <= T2_DEF;
            r.rxto <= RXTO_DEF;
            r.rst_s <= 2'h3;
        end else begin
            r <= next_r;
        end
    end
    // Outputs straight from flops, seq_on decoded from the state register
    assign lnk.ref_clock_out = r.ckdiv;
    assign lnk.chip_mode = r.mode;
    assign lnk.seq_on = (r.st != S_OFF) && (r.st != S_BOOT);
    assign lnk.event_line_4 = r.lines[2];
    assign lnk.event_line_2 = r.lines[1];
    assign lnk.event_line_0 = r.lines[0];
    assign lnk.irq = r.irq;
endmodule

// file: hdl/tmsq_host.sv
// Host end: AXI4-Lite registers that drive the device link
`timescale 1ns/1ns
module tmsq_host
    import tmsq_pkg::*;
#(
    parameter int POR_CYC = POR_WAIT_CYC,
    parameter int MAN_CYC = MAN_WAIT_CYC,
    parameter int PULSE_CYC = RESET_PULSE_CYC
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Link
    tmsq_link_if.host lnk
);
    typedef struct packed {
        logic aw_ok;
        logic w_ok;
        logic [7:0] awa;
        logic [31:0] wd;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [CFG_W-1:0] cfg;
        logic [TW-1:0] t1;
        logic [TW-1:0] t2;
        logic [TW-1:0] rxto;
        logic [2:0] mode;
        logic cfg_we;
        logic mode_we;
        logic start;
        logic halt;
        logic rst_n;
        logic [31:0] wait_cnt;
        logic busy;
        logic [2:0] in_s1;
        logic [2:0] in_s2;
    } tmsq_host_t;
    tmsq_host_t r;
    tmsq_host_t next_r;
    logic [31:0] wv;
    always_comb begin
        next_r = r;
        wv = r.wd;
        next_r.in_s1 = {lnk.ref_clock_out, lnk.seq_on, lnk.irq};
        next_r.in_s2 = r.in_s1;
        next_r.cfg_we = 1'b0;
        next_r.mode_we = 1'b0;
        next_r.start = 1'b0;
        if (s_axi_awvalid && !r.aw_ok && !r.bvalid) begin
            next_r.aw_ok = 1'b1;
            next_r.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r.w_ok && !r.bvalid) begin
            next_r.w_ok = 1'b1;
            next_r.wd = s_axi_wdata;
        end
        if (r.wait_cnt != 32'h00000000) begin
            next_r.wait_cnt = r.wait_cnt - 32'h00000001;
            if (r.wait_cnt == 32'(MAN_CYC)) begin
                next_r.rst_n = 1'b1;
            end
        end else if (r.in_s2[2]) begin
            next_r.busy = 1'b0;
        end
        if (r.aw_ok && r.w_ok) begin
            next_r.aw_ok = 1'b0;
            next_r.w_ok = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = RESP_OK;
            if (r.busy && r.awa != REG_CTRL) begin
                next_r.bresp = RESP_ERR;
            end else begin
                unique case (r.awa)
                    REG_CTRL: begin
                        next_r.halt = wv[CTRL_HALT];
                        next_r.start = wv[CTRL_START];
                        next_r.mode_we = wv[CTRL_WMODE];
                        if (wv[CTRL_RESET]) begin
                            next_r.rst_n = 1'b0;
                            next_r.busy = 1'b1;
                            next_r.wait_cnt = 32'(MAN_CYC + PULSE_CYC);
                        end
                    end
                    REG_CFG: begin
                        next_r.cfg = wv[CFG_W-1:0];
                        next_r.cfg_we = 1'b1;
                    end
                    REG_T1: begin
                        next_r.t1 = wv[TW-1:0];
                        next_r.cfg_we = 1'b1;
                    end
                    REG_T2: begin
                        next_r.t2 = wv[TW-1:0];
                        next_r.cfg_we = 1'b1;
                    end
                    REG_RXTO: begin
                        next_r.rxto = wv[TW-1:0];
                        next_r.cfg_we = 1'b1;
                    end
                    REG_MODE: next_r.mode = wv[2:0];
                    default: next_r.bresp = RESP_ERR;
                endcase
            end
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end
        if (s_axi_arvalid && !r.rvalid) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = RESP_OK;
            unique case (s_axi_araddr)
                REG_CTRL: next_r.rdata = {30'h00000000, r.halt, 1'b0};
                REG_CFG: next_r.rdata = {13'h0000, r.cfg};
                REG_T1: next_r.rdata = {8'h00, r.t1};
                REG_T2: next_r.rdata = {8'h00, r.t2};
                REG_RXTO: next_r.rdata = {8'h00, r.rxto};
                REG_STAT: next_r.rdata = {25'h0000000, lnk.chip_mode, 1'b0, r.busy, r.in_s2[1:0]};
                REG_MODE: next_r.rdata = {29'h00000000, r.mode};
                default: begin
                    next_r.rdata = 32'h00000000;
                    next_r.rresp = RESP_ERR;
                end
            endcase
        end
        if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.t1 <= T1_DEF;
            r.t2 <= T2_DEF;
            r.rxto <= RXTO_DEF;
            r.rst_n <= 1'b1;
            r.busy <= 1'b1;
            r.wait_cnt <= 32'(POR_CYC);
        end else begin
            r <= next_r;
        end
    end
    assign s_axi_awready = !r.aw_ok && !r.bvalid;
    assign s_axi_wready = !r.w_ok && !r.bvalid;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = !r.rvalid;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign lnk.ext_reset_n = r.rst_n;
    assign lnk.cfg_we = r.cfg_we;
    assign lnk.cfg = r.cfg;
    assign lnk.t1_len = r.t1;
    assign lnk.t2_len = r.t2;
    assign lnk.rxto_len = r.rxto;
    assign lnk.start_pulse = r.start;
    assign lnk.seq_halt_bit = r.halt;
    assign lnk.mode_we = r.mode_we;
    assign lnk.mode_wdata = r.mode;
endmodule

// file: verification/tmsq_link_asserts.sv
// Checker: assertions on the link between the host and device ends
`timescale 1ns/1ns
module tmsq_link_asserts
    import tmsq_pkg::*;
(
    // Clock and reset
    input logic aclk,
    input logic aresetn,
    // Host side of the link
    input tmsq_cfg_t cfg,
    input logic [TW-1:0] t2_len,
    input logic start_pulse,
    input logic seq_halt_bit,
    input logic mode_we,
    // Device side of the link
    input logic ref_clock_out,
    input logic [2:0] chip_mode,
    input logic seq_on,
    input logic event_line_4,
    input logic irq,
    // Radio events
    input logic preamble_found_event,
    input logic sync_match_event,
    input logic tx_done_event,
    input logic rx_payload_event
);
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////
    // Ready flag and length of the sequenced receive
    logic ready;
    logic [TW:0] rx_cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ready <= 1'h0;
            rx_cnt <= '0;
        end else begin
            ready <= ready | ref_clock_out;
            rx_cnt <= (seq_on && chip_mode == MODE_RX) ? rx_cnt + 1'h1 : '0;
        end
    end

    ////////////////////////////////////////////////////////////////
    sequence s_toggle;
        !ref_clock_out ##1 ref_clock_out;
    endsequence
    sequence s_in_rx;
        seq_on && chip_mode == MODE_RX;
    endsequence
    sequence s_rx_held;
        ##[1:8] (!seq_on && chip_mode == MODE_RX);
    endsequence

    a_ref_clock_runs: assert property ($rose(ref_clock_out) |=> s_toggle)
        else $error("reference clock stopped");
    a_preamble_stop: assert property (
        s_in_rx ##0 (cfg.rx_transition == RXT_OFF_PRE && $rose(preamble_found_event))
        |-> s_rx_held) else $error("no stop on preamble");
    a_sync_stop: assert property (
        s_in_rx ##0 (cfg.rx_transition == RXT_OFF_SYNC && $rose(sync_match_event))
        |-> s_rx_held) else $error("no stop on sync match");
    a_sent_to_idle: assert property (
        seq_on && chip_mode == MODE_TX && !cfg.tx_transition && cfg.idle_power_select
        && cfg.low_power_choice && $rose(tx_done_event) |-> ##[1:8] chip_mode == MODE_SLEEP)
        else $error("no sleep after packet sent");
    a_rx_irq: assert property ($rose(rx_payload_event) |-> ##[1:8] irq)
        else $error("no interrupt request on packet");
    a_preamble_line4: assert property (
        cfg.preamble_event_route_bit && cfg.map_line4 == MAP_PREAMBLE
        && $rose(preamble_found_event) |-> ##[1:8] event_line_4)
        else $error("preamble not on event line 4");
    a_halt_stops: assert property ($rose(seq_halt_bit) |-> ##[1:8] !seq_on)
        else $error("halt ignored");
    a_off_mode_kept: assert property (
        (ready && !seq_on && !mode_we && !start_pulse) [*8] |=> $stable(chip_mode))
        else $error("mode moved while sequencer off");
    a_rx_window: assert property (seq_on |-> rx_cnt <= t2_len + 8)
        else $error("receive outlasted second timer");
endmodule

// file: verification/tmsq_tb.sv
// Testbench: host and device ends joined over the link
`timescale 1ns/1ns
module tmsq_tb;
    import tmsq_pkg::*;
    localparam int LIMIT = 90000;
    logic aclk, aresetn;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [4:0] ev;
    tmsq_cfg_t c;
    int bad_count = 0;
    int compares = 0;
    int cyc = 0;

    tmsq_link_if lnk();
    tmsq_host #(.POR_CYC(50), .MAN_CYC(20), .PULSE_CYC(5)) tmsq_host_i (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .lnk(lnk));
    tmsq_device tmsq_device_i (.aclk, .aresetn, .lnk(lnk), .preamble_found_event(ev[0]),
        .sync_match_event(ev[1]), .tx_done_event(ev[2]), .rx_payload_event(ev[3]),
        .check_pass_event(ev[4]));
    tmsq_link_asserts tmsq_link_asserts_i (.aclk, .aresetn, .cfg(lnk.cfg),
        .t2_len(lnk.t2_len), .start_pulse(lnk.start_pulse), .seq_halt_bit(lnk.seq_halt_bit),
        .mode_we(lnk.mode_we), .ref_clock_out(lnk.ref_clock_out), .chip_mode(lnk.chip_mode),
        .seq_on(lnk.seq_on), .event_line_4(lnk.event_line_4), .irq(lnk.irq),
        .preamble_found_event(ev[0]), .sync_match_event(ev[1]), .tx_done_event(ev[2]),
        .rx_payload_event(ev[3]));

    ////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'h0;
        forever #20 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            bad_count++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task give_verdict;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task wait_mode(input logic [2:0] m, input int n);
        for (int i = 0; i < n && lnk.chip_mode !== m; i++) @(posedge aclk);
        check("chip_mode", 32'(lnk.chip_mode), 32'(m));
    endtask
    // Hold radio events for six cycles, long enough to pass the synchronisers
    task raise(input logic [4:0] m);
        ev <= m;
        repeat (6) @(posedge aclk);
    endtask

    ////////////////////////////////////////////////////////////////
    task s_boot;
        wr(REG_T1, 32'h14);
        check("early write", 32'(r), 32'(RESP_ERR));
        check("ext_reset_n", 32'(lnk.ext_reset_n), 32'h1);
        check("ref clock idle", 32'(lnk.ref_clock_out), 32'h0);
        for (int i = 0; i < 70000 && lnk.ref_clock_out !== 1'h1; i++) @(posedge aclk);
        check("ref clock ready", 32'(lnk.ref_clock_out), 32'h1);
        repeat (4) @(posedge aclk);
        rd(REG_STAT);
        check("busy", 32'(d[2]), 32'h0);
        rd(8'h40);
        check("unmapped resp", 32'(r), 32'(RESP_ERR));
        check("unmapped data", d, 32'h0);
        wr(REG_T1, 32'h14);
        check("t1 write", 32'(r), 32'(RESP_OK));
        wr(REG_T2, 32'h28);
        wr(REG_RXTO, 32'h0A);
    endtask
    task s_preamble;
        c = '{1'h1, START_TO_LPS, 1'h1, 1'h1, RXT_OFF_PRE, 2'h0, 1'h0, 1'h0, 1'h1,
            MAP_PREAMBLE, MAP_SYNC, MAP_CHECK};
        wr(REG_CFG, 32'(c));
        wr(REG_CTRL, 32'(1 << CTRL_START));
        wait_mode(MODE_SLEEP, 20);
        wait_mode(MODE_RX, 100);
        check("seq_on", 32'(lnk.seq_on), 32'h1);
        wait_mode(MODE_SLEEP, 60);
        wait_mode(MODE_RX, 100);
        raise(5'h01);
        check("line 4", 32'(lnk.event_line_4), 32'h1);
        ev <= 5'h00;
        repeat (60) @(posedge aclk);
        check("seq off", 32'(lnk.seq_on), 32'h0);
        check("held rx", 32'(lnk.chip_mode), 32'(MODE_RX));
        wr(REG_MODE, 32'(MODE_SLEEP));
        wr(REG_CTRL, 32'(1 << CTRL_WMODE));
        wait_mode(MODE_SLEEP, 20);
    endtask
    task s_sync;
        c.rx_transition = RXT_OFF_SYNC;
        c.rx_timeout_transition = RXTO_TO_LPS;
        wr(REG_CFG, 32'(c));
        wr(REG_CTRL, 32'(1 << CTRL_START));
        wait_mode(MODE_RX, 100);
        wait_mode(MODE_SLEEP, 30);
        wait_mode(MODE_RX, 100);
        raise(5'h01);
        ev <= 5'h00;
        repeat (14) @(posedge aclk);
        check("rx past timeout", 32'(lnk.chip_mode), 32'(MODE_RX));
        wait_mode(MODE_SLEEP, 40);
        wait_mode(MODE_RX, 100);
        raise(5'h02);
        check("line 2", 32'(lnk.event_line_2), 32'h1);
        check("seq off", 32'(lnk.seq_on), 32'h0);
        raise(5'h18);
        check("irq", 32'(lnk.irq), 32'h1);
        check("line 0", 32'(lnk.event_line_0), 32'h1);
        ev <= 5'h00;
        rd(REG_STAT);
        check("stat mode", 32'(d[6:4]), 32'(MODE_RX));
        wr(REG_MODE, 32'(MODE_SLEEP));
        wr(REG_CTRL, 32'(1 << CTRL_WMODE));
        wait_mode(MODE_SLEEP, 20);
    endtask
    task s_beacon;
        c.idle_transition = 1'h0;
        c.tx_transition = 1'h0;
        c.beacon_repeat_enable = 1'h1;
        wr(REG_CFG, 32'(c));
        wr(REG_CTRL, 32'(1 << CTRL_START));
        for (int k = 0; k < 2; k++) begin
            wait_mode(MODE_TX, 100);
            raise(5'h04);
            ev <= 5'h00;
            wait_mode(MODE_SLEEP, 20);
        end
        wait_mode(MODE_TX, 100);
        wr(REG_CTRL, 32'(1 << CTRL_HALT));
        repeat (4) @(posedge aclk);
        check("halted", 32'(lnk.seq_on), 32'h0);
        wr(REG_MODE, 32'(MODE_SLEEP));
        wr(REG_CTRL, 32'((1 << CTRL_HALT) | (1 << CTRL_WMODE)));
        wait_mode(MODE_SLEEP, 20);
        repeat (80) @(posedge aclk);
        check("no beacon", 32'(lnk.chip_mode), 32'(MODE_SLEEP));
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        aresetn = 1'h0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        ev = 5'h00;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        s_boot();
        s_preamble();
        s_sync();
        s_beacon();
        give_verdict();
    end
endmodule
